// ---- pkg/adc_mode_pkg.sv ----
// Constants and carrier types for the converter mode control block.
// Assumes a 32-bit APB master and one 10 MHz device clock.
package adc_mode_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_LINK_MODE = 8'h00;
   localparam logic [7:0] OFS_INPUT_MUX = 8'h04;
   localparam logic [7:0] OFS_K_PARAM   = 8'h08;
   localparam logic [7:0] OFS_LINK_EN   = 8'h0c;
   localparam logic [7:0] OFS_CH_POWER  = 8'h10;
   localparam logic [7:0] OFS_DERIVED   = 8'h14;
   localparam logic [7:0] OFS_CORE_STAT = 8'h18;

   // ----------------------------------------------------------------
   // Field positions and widths
   // ----------------------------------------------------------------
   localparam int MODE_W       = 5;
   localparam int KM1_W        = 8;
   localparam int MUX_SWAP_BIT = 0;
   localparam int MUX_SEL_LSB  = 4;
   localparam int EN_BIT       = 0;
   localparam int PD_A_BIT     = 0;
   localparam int PD_B_BIT     = 1;

   // ----------------------------------------------------------------
   // Reset values and encodings
   // ----------------------------------------------------------------
   localparam logic [4:0] RST_LINK_MODE = 5'h00;
   localparam logic [7:0] RST_KM1       = 8'h03;
   localparam logic [1:0] SEL_FIRST     = 2'h0;
   localparam logic [1:0] SEL_SECOND    = 2'h1;
   localparam logic [1:0] SEL_BOTH      = 2'h2;
   localparam logic [4:0] NUM_MODES     = 5'h03;
   localparam logic [4:0] R_MODE0       = 5'h04;
   localparam logic [4:0] R_MODE1       = 5'h02;
   localparam logic [4:0] R_MODE2       = 5'h04;
   localparam logic [1:0] LINKS_TABLE   = 2'h2;
   localparam logic [4:0] R_PLL_BYPASS  = 5'h01;
   localparam logic [1:0] E_FIXED       = 2'h1;

   // ----------------------------------------------------------------
   // Derived link parameters, also the read layout at OFS_DERIVED
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [8:0] rsvd;
      logic       mode_valid;
      logic       pll_bypass;
      logic [1:0] e_blocks;
      logic [8:0] k_frames;
      logic [1:0] links;
      logic [4:0] r_factor;
      logic       enc_64b66b;
      logic       dual_input;
      logic       interleave;
   } link_param_t;

   // Converter core steering, read layout at OFS_CORE_STAT
   typedef struct packed {
      logic [25:0] rsvd;
      logic        rate_x2;
      logic        core_b_half_phase;
      logic        core_b_power;
      logic        core_a_power;
      logic        core_b_input;
      logic        core_a_input;
   } core_ctrl_t;

endpackage

// ---- verilog/adc_mode_ctrl.sv ----
// Mode, input mux and serial link parameter control for the converter.
// Assumes an APB master on clk and a calibration engine on the same
// clock that pulses cal_done once when a calibration finishes.

// Summary of operation
// - Dual mode samples each channel at clock rate
// - Dual mode: first input to first channel
// - Swap field exchanges the two dual inputs
// - One channel may power down in dual
// - Interleaved mode runs both cores at twice clock
// - Interleaved input chosen by select field
// - Dual input mode: cores out of phase
// - Dual input link output as single mode
// - Link mode derives all link parameters but K and the dual input flag
// - Interleave flag one single, zero dual
// - Lane rate factor sets PLL or bypass
// - K from minus-one field, 8b/10b only
// - E fixed at one, 64b/66b only
// - Link count derived from link mode
module adc_mode_ctrl
(
   input  wire logic                      clk,
   input  wire logic                      nrst,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      cal_done,
   output adc_mode_pkg::link_param_t      link_params,
   output adc_mode_pkg::core_ctrl_t       core_ctrl,
   output logic                           link_block_reset,
   output logic                           serializer_power_down
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [4:0]                 link_mode_select_r;
   logic                       swap_r;
   logic [1:0]                 single_sel_r;
   logic [1:0]                 calibrated_sel_r;
   logic [7:0]                 frames_per_multiframe_minus_one_r;
   logic                       serial_link_enable_r;
   logic                       pd_a_r;
   logic                       pd_b_r;

   logic [4:0]                 act_mode_r;
   logic                       act_swap_r;
   logic [1:0]                 act_sel_r;
   logic [7:0]                 act_km1_r;
   logic                       act_pd_a_r;
   logic                       act_pd_b_r;

   adc_mode_pkg::link_param_t  params_nxt;
   adc_mode_pkg::link_param_t  params_r;
   adc_mode_pkg::core_ctrl_t   core_nxt;
   adc_mode_pkg::core_ctrl_t   core_r;

   logic                       setup_phase;
   logic                       access_phase;
   logic                       wr_en;
   logic                       addr_hit;
   logic                       addr_hit_r;
   logic [31:0]                rd_nxt;
   logic [31:0]                prdata_r;

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------

   // Zero wait states; the read word is latched in the setup cycle
   assign setup_phase  = psel & ~penable;
   assign access_phase = psel & penable;
   assign pready       = 1'b1;
   assign wr_en        = access_phase & pwrite & addr_hit_r;
   assign pslverr      = access_phase & ~addr_hit_r;
   assign prdata       = prdata_r;

   // Address decode, word aligned only
   always_comb
   begin
      addr_hit = 1'b0;
      unique case (paddr)
         adc_mode_pkg::OFS_LINK_MODE,
         adc_mode_pkg::OFS_INPUT_MUX,
         adc_mode_pkg::OFS_K_PARAM,
         adc_mode_pkg::OFS_LINK_EN,
         adc_mode_pkg::OFS_CH_POWER,
         adc_mode_pkg::OFS_DERIVED,
         adc_mode_pkg::OFS_CORE_STAT: addr_hit = 1'b1;
         default:                     addr_hit = 1'b0;
      endcase
   end

   // Read multiplexer; unused bits read as zero
   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      unique case (paddr)
         adc_mode_pkg::OFS_LINK_MODE:
            rd_nxt[adc_mode_pkg::MODE_W-1:0] = link_mode_select_r;
         adc_mode_pkg::OFS_INPUT_MUX:
         begin
            rd_nxt[adc_mode_pkg::MUX_SWAP_BIT] = swap_r;
            rd_nxt[adc_mode_pkg::MUX_SEL_LSB +: 2] = single_sel_r;
         end
         adc_mode_pkg::OFS_K_PARAM:
            rd_nxt[adc_mode_pkg::KM1_W-1:0] = frames_per_multiframe_minus_one_r;
         adc_mode_pkg::OFS_LINK_EN:
            rd_nxt[adc_mode_pkg::EN_BIT] = serial_link_enable_r;
         adc_mode_pkg::OFS_CH_POWER:
         begin
            rd_nxt[adc_mode_pkg::PD_A_BIT] = pd_a_r;
            rd_nxt[adc_mode_pkg::PD_B_BIT] = pd_b_r;
         end
         adc_mode_pkg::OFS_DERIVED:   rd_nxt = params_r;
         adc_mode_pkg::OFS_CORE_STAT: rd_nxt = core_r;
         default:                     rd_nxt = 32'h0000_0000;
      endcase
   end

   // Capture read data and decode result at setup
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         prdata_r   <= 32'h0000_0000;
         addr_hit_r <= 1'b0;
      end
      else if (setup_phase)
      begin
         prdata_r   <= pwrite ? 32'h0000_0000 : rd_nxt;
         addr_hit_r <= addr_hit;
      end
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------

   // Mode selection; takes effect only while the link is off
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         link_mode_select_r <= adc_mode_pkg::RST_LINK_MODE;
      else if (wr_en && paddr == adc_mode_pkg::OFS_LINK_MODE)
         link_mode_select_r <= pwdata[adc_mode_pkg::MODE_W-1:0];
   end

   // Input mux: swap bit and interleaved input select
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         swap_r       <= 1'b0;
         single_sel_r <= adc_mode_pkg::SEL_FIRST;
      end
      else if (wr_en && paddr == adc_mode_pkg::OFS_INPUT_MUX)
      begin
         swap_r       <= pwdata[adc_mode_pkg::MUX_SWAP_BIT];
         single_sel_r <= pwdata[adc_mode_pkg::MUX_SEL_LSB +: 2];
      end
   end

   // New interleaved input only after a calibration completes
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         calibrated_sel_r <= adc_mode_pkg::SEL_FIRST;
      else if (cal_done)
         calibrated_sel_r <= single_sel_r;
   end

   // Frames per multiframe, stored as value minus one
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         frames_per_multiframe_minus_one_r <= adc_mode_pkg::RST_KM1;
      else if (wr_en && paddr == adc_mode_pkg::OFS_K_PARAM)
         frames_per_multiframe_minus_one_r <= pwdata[adc_mode_pkg::KM1_W-1:0];
   end

   // Serial link enable
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         serial_link_enable_r <= 1'b0;
      else if (wr_en && paddr == adc_mode_pkg::OFS_LINK_EN)
         serial_link_enable_r <= pwdata[adc_mode_pkg::EN_BIT];
   end

   // Per-channel power down requests
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pd_a_r <= 1'b0;
         pd_b_r <= 1'b0;
      end
      else if (wr_en && paddr == adc_mode_pkg::OFS_CH_POWER)
      begin
         pd_a_r <= pwdata[adc_mode_pkg::PD_A_BIT];
         pd_b_r <= pwdata[adc_mode_pkg::PD_B_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Active settings
   // ----------------------------------------------------------------

   // Frozen while the link runs, so a careless write cannot
   // corrupt a live link; software still sees its own written value
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         act_mode_r <= adc_mode_pkg::RST_LINK_MODE;
         act_swap_r <= 1'b0;
         act_sel_r  <= adc_mode_pkg::SEL_FIRST;
         act_km1_r  <= adc_mode_pkg::RST_KM1;
         act_pd_a_r <= 1'b0;
         act_pd_b_r <= 1'b0;
      end
      else if (!serial_link_enable_r)
      begin
         act_mode_r <= link_mode_select_r;
         act_swap_r <= swap_r;
         act_sel_r  <= calibrated_sel_r;
         act_km1_r  <= frames_per_multiframe_minus_one_r;
         act_pd_a_r <= pd_a_r;
         act_pd_b_r <= pd_b_r;
      end
   end

   // ----------------------------------------------------------------
   // Derived link parameters
   // ----------------------------------------------------------------

   // Mode table lookup; unknown modes report invalid with zeros
   always_comb
   begin
      params_nxt = '0;
      unique case (act_mode_r)
         5'h00:
         begin
            params_nxt.interleave = 1'b1;
            params_nxt.r_factor   = adc_mode_pkg::R_MODE0;
         end
         5'h01:
         begin
            params_nxt.interleave = 1'b1;
            params_nxt.r_factor   = adc_mode_pkg::R_MODE1;
         end
         5'h02:
         begin
            params_nxt.interleave = 1'b0;
            params_nxt.r_factor   = adc_mode_pkg::R_MODE2;
         end
         default:
            params_nxt.r_factor = 5'h00;
      endcase
      params_nxt.mode_valid = act_mode_r < adc_mode_pkg::NUM_MODES;
      if (params_nxt.mode_valid)
         params_nxt.links = adc_mode_pkg::LINKS_TABLE;
      // Known modes all use 8b/10b
      params_nxt.enc_64b66b = 1'b0;
      // Lane rate = clock x R; a factor of one skips the PLL
      params_nxt.pll_bypass = params_nxt.mode_valid
                            & (params_nxt.r_factor == adc_mode_pkg::R_PLL_BYPASS);
      // K only means something in 8b/10b
      if (params_nxt.mode_valid && !params_nxt.enc_64b66b)
         params_nxt.k_frames = {1'b0, act_km1_r} + 9'h001;
      // E only means something in 64b/66b
      if (params_nxt.mode_valid && params_nxt.enc_64b66b)
         params_nxt.e_blocks = adc_mode_pkg::E_FIXED;
      // Both inputs flag; link format unchanged by it
      params_nxt.dual_input = params_nxt.interleave
                            & act_sel_r[1];
   end

   // ----------------------------------------------------------------
   // Converter core steering
   // ----------------------------------------------------------------

   // Input routing, phase and power of the two cores
   always_comb
   begin
      core_nxt = '0;
      if (params_nxt.interleave)
      begin
         // Both cores run; combined rate is twice the clock
         core_nxt.rate_x2      = 1'b1;
         core_nxt.core_a_power = 1'b1;
         core_nxt.core_b_power = 1'b1;
         core_nxt.core_b_half_phase = 1'b1;
         if (act_sel_r[1])
         begin
            // Each core on its own input, out of phase
            core_nxt.core_a_input = 1'b0;
            core_nxt.core_b_input = 1'b1;
         end
         else
         begin
            core_nxt.core_a_input = act_sel_r[0];
            core_nxt.core_b_input = act_sel_r[0];
         end
      end
      else
      begin
         // One sample per core per clock
         core_nxt.rate_x2      = 1'b0;
         core_nxt.core_a_input = act_swap_r;
         core_nxt.core_b_input = ~act_swap_r;
         core_nxt.core_a_power = ~act_pd_a_r;
         core_nxt.core_b_power = ~act_pd_b_r;
      end
   end

   // Registered so the outputs never glitch on a mode change
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         params_r <= '0;
         core_r   <= '0;
      end
      else
      begin
         params_r <= params_nxt;
         core_r   <= core_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Link block control
   // ----------------------------------------------------------------

   // Link held in reset and serializers off while disabled
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         link_block_reset      <= 1'b1;
         serializer_power_down <= 1'b1;
      end
      else
      begin
         link_block_reset      <= ~serial_link_enable_r;
         serializer_power_down <= ~serial_link_enable_r;
      end
   end

   // Outputs from flip-flops
   assign link_params = params_r;
   assign core_ctrl   = core_r;

endmodule

// ---- bench/adc_mode_chk.sv ----
// Concurrent checks on the mode control outputs, bound to the top.
// Assumes one clock domain and the active-low asynchronous reset.
module adc_mode_chk
(
   input wire logic                       clk,
   input wire logic                       nrst,
   input wire logic                       pready,
   input wire adc_mode_pkg::link_param_t  link_params,
   input wire adc_mode_pkg::core_ctrl_t   core_ctrl,
   input wire logic                       link_block_reset,
   input wire logic                       serializer_power_down
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // ----
   // Link held on long enough for the last load to land
   // ----
   sequence s_link_on;
      !link_block_reset && !$past(link_block_reset) && !$past(link_block_reset, 2);
   endsequence

   a_rate_double: assert property (core_ctrl.rate_x2 == link_params.interleave)
      else $error("rate flag and interleave disagree");
   a_half_phase: assert property (core_ctrl.core_b_half_phase == link_params.interleave)
      else $error("core b phase wrong");
   a_dual_route: assert property (link_params.mode_valid && !link_params.interleave
      |-> core_ctrl.core_a_input != core_ctrl.core_b_input) else $error("dual inputs shared");
   a_dual_input: assert property (link_params.dual_input |-> link_params.interleave
      && !core_ctrl.core_a_input && core_ctrl.core_b_input) else $error("dual input steering");
   a_single_power: assert property (link_params.interleave
      |-> core_ctrl.core_a_power && core_ctrl.core_b_power) else $error("core off in single");
   a_pll_bypass: assert property (link_params.pll_bypass == (link_params.r_factor == 5'h01))
      else $error("pll bypass wrong");
   a_e_fixed: assert property (link_params.e_blocks
      == (link_params.enc_64b66b ? 2'h1 : 2'h0)) else $error("e value wrong");
   a_k_range: assert property (link_params.mode_valid && !link_params.enc_64b66b
      |-> link_params.k_frames inside {[9'h001:9'h100]}) else $error("k out of range");
   a_links_fixed: assert property (link_params.links
      == (link_params.mode_valid ? 2'h2 : 2'h0)) else $error("link count wrong");
   a_zero_wait: assert property (pready)
      else $error("slave inserted a wait state");
   a_link_off: assert property (link_block_reset == serializer_power_down)
      else $error("reset and power down differ");
   a_hold_on: assert property (s_link_on |-> $stable(link_params) && $stable(core_ctrl))
      else $error("settings moved while link on");
endmodule

bind adc_mode_ctrl adc_mode_chk u_chk (.clk, .nrst, .pready, .link_params, .core_ctrl,
   .link_block_reset, .serializer_power_down);

// ---- bench/cal_engine.sv ----
// Calibration engine model on the far side of the select path.
// Assumes requests are one-cycle pulses on the device clock.
module cal_engine
(
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       cal_req,
   input  wire logic [3:0] cal_dly,
   output logic            cal_done
);
   logic [4:0] cnt_r;

   // Delay chosen per request, so prompt and slow answers both occur
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_r    <= 5'h00;
         cal_done <= 1'b0;
      end
      else
      begin
         cal_done <= (cnt_r == 5'h01);
         if (cal_req)
            cnt_r <= {1'b0, cal_dly} + 5'h01;
         else if (cnt_r != 5'h00)
            cnt_r <= cnt_r - 5'h01;
      end
   end
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench: APB master, reference model, calibration model.
// Assumes the design answers APB with pready and updates outputs two edges on.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                      clk, nrst, psel, penable, pwrite, cal_req;
   logic [7:0]                paddr;
   logic [31:0]               pwdata, prdata, q, v;
   logic                      pready, pslverr, cal_done, lbr, spd, e;
   logic [3:0]                cal_dly;
   adc_mode_pkg::link_param_t link_params;
   adc_mode_pkg::core_ctrl_t  core_ctrl;
   int                        err_count, checks_done, cycles, i, seed;
   int                        m_mode, m_swap, m_sel, m_km1, m_en, m_pd, m_cal;
   int                        a_mode, a_swap, a_sel, a_km1, a_pd;

   adc_mode_ctrl u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cal_done(cal_done), .link_params(link_params),
      .core_ctrl(core_ctrl), .link_block_reset(lbr), .serializer_power_down(spd));
   cal_engine u_cal (.clk(clk), .nrst(nrst), .cal_req(cal_req), .cal_dly(cal_dly),
      .cal_done(cal_done));

   // Clock and a hang guard well above the expected run length
   always #50 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         end_of_test;
      end
   end

   task automatic end_of_test;
      if (err_count == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // ----
   // APB master: request held until pready seen at an edge
   // ----
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // No local limit: only the cycle ceiling may end a stuck wait
      while (pready !== 1'b1)
         @(posedge clk);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Active copy loads only while the link is off
   task automatic load;
      if (m_en == 0)
      begin
         a_mode = m_mode;
         a_swap = m_swap;
         a_km1  = m_km1;
         a_pd   = m_pd;
         a_sel  = m_cal;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      chk(e, 0);
      case (a)
         8'h00: m_mode = d[4:0];
         8'h04:
         begin
            // Separate fields; a packed concat into two ints misplaces them
            m_sel  = d[5:4];
            m_swap = d[0];
         end
         8'h08: m_km1 = d[7:0];
         8'h0c: m_en = d[0];
         8'h10: m_pd = d[1:0];
         default: ;
      endcase
      load;
   endtask

   task automatic calibrate(input logic [3:0] d);
      @(posedge clk);
      cal_dly <= d;
      cal_req <= 1'b1;
      @(posedge clk);
      cal_req <= 1'b0;
      while (cal_done !== 1'b1)
         @(posedge clk);
      m_cal = m_sel;
      if (m_en == 0)
         a_sel = m_cal;
   endtask

   function automatic logic [63:0] expv();
      adc_mode_pkg::link_param_t lp;
      adc_mode_pkg::core_ctrl_t  cc;
      logic                      one;
      lp  = '0;
      cc  = '0;
      one = (a_mode < 2);
      if (a_mode < 3)
      begin
         lp.mode_valid = 1'b1;
         lp.interleave = one;
         lp.r_factor   = (a_mode == 1) ? 5'h02 : 5'h04;
         lp.links      = 2'h2;
         lp.k_frames   = 9'(a_km1 + 1);
         lp.dual_input = one && (a_sel > 1);
      end
      if (one)
      begin
         cc.rate_x2           = 1'b1;
         cc.core_b_half_phase = 1'b1;
         {cc.core_a_power, cc.core_b_power} = 2'h3;
         cc.core_a_input      = (a_sel == 1);
         cc.core_b_input      = (a_sel != 0);
      end
      else
      begin
         cc.core_a_input = a_swap[0];
         cc.core_b_input = !a_swap[0];
         cc.core_a_power = !a_pd[0];
         cc.core_b_power = !a_pd[1];
      end
      return {lp, cc};
   endfunction

   // Register readback plus derived outputs against the model
   task automatic check_all;
      logic [63:0] x;
      repeat (2) @(posedge clk);
      x = expv();
      apb(1'b0, 8'h00, 32'h0);
      chk(q, m_mode);
      apb(1'b0, 8'h04, 32'h0);
      chk(q, (m_sel << 4) | m_swap);
      apb(1'b0, 8'h08, 32'h0);
      chk(q, m_km1);
      apb(1'b0, 8'h0c, 32'h0);
      chk(q, m_en);
      apb(1'b0, 8'h10, 32'h0);
      chk(q, m_pd);
      apb(1'b0, 8'h14, 32'h0);
      chk(q, x[63:32]);
      apb(1'b0, 8'h18, 32'h0);
      chk(q, x[31:0]);
      @(negedge clk);
      chk(link_params, x[63:32]);
      chk(core_ctrl, x[31:0]);
      chk({lbr, spd}, (m_en != 0) ? 0 : 3);
   endtask

   initial
   begin
      {clk, nrst, psel, penable, pwrite, cal_req} = 6'h00;
      {paddr, pwdata, cal_dly} = '0;
      {m_mode, m_swap, m_sel, m_en, m_pd, m_cal} = '0;
      m_km1 = 3;
      seed  = 32'h4b43;
      load;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      check_all;
      // Every mode, then reserved modes 3, 4 and 31; select waits for calibration
      for (i = 0; i < 6; i++)
      begin
         v = $random(seed);
         wr(8'h00, (i == 5) ? 31 : i);
         wr(8'h04, v & 32'h31);
         wr(8'h08, v[15:8]);
         wr(8'h10, v[17:16]);
         check_all;
         calibrate(v[23:20]);
         check_all;
      end
      wr(8'h00, 0);
      wr(8'h04, 32'h20);
      calibrate(4'h0);
      check_all;
      // Link on freezes the active set; off releases it
      wr(8'h0c, 1);
      wr(8'h00, 2);
      wr(8'h04, 32'h11);
      calibrate(4'h3);
      check_all;
      wr(8'h0c, 0);
      check_all;
      // Read-only write is quiet, unmapped place errors
      apb(1'b1, 8'h14, 32'hffffffff);
      chk(e, 0);
      apb(1'b1, 8'h1c, 32'hffffffff);
      chk(e, 1);
      apb(1'b0, 8'h1c, 32'h0);
      chk({e, q}, 33'h100000000);
      check_all;
      end_of_test;
   end
endmodule
